//--- pkg/cafm_pkg.sv
// Constants, register map and helpers for the acceptance filter block.
package cafm_pkg;

  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS   = 3;
  localparam int IDX_W       = 4;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int SID_W       = 11;
  localparam int EID_W       = 18;
  localparam int PTR_W       = 4;

  localparam logic [ADDR_W-1:0] ADDR_FSID_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FEID_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MSEL_LO   = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_MSEL_HI   = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_MSID_BASE = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_MEID_BASE = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_FEN       = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_BPTR_BASE = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h2D;
  localparam logic [ADDR_W-1:0] CNT_FILTERS    = 8'h10;
  localparam logic [ADDR_W-1:0] CNT_MASKS      = 8'h03;
  localparam logic [ADDR_W-1:0] CNT_BPTR       = 8'h04;

  localparam int SID_MSB   = 15;
  localparam int SID_LSB   = 5;
  localparam int FILTER_FRAME_TYPE_SELECT_POS = 3;
  localparam int MASK_TYPE_MATCH_MODE_POS  = 3;
  localparam int EIDH_MSB  = 1;
  localparam int STAT_HIT_POS = 8;
  localparam int STAT_IDX_LSB = 4;

  localparam logic [DATA_W-1:0] SID_IMPL_MASK = 16'hFFEB;
  localparam logic [DATA_W-1:0] RST_ID        = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MSEL      = 16'h0000;
  localparam logic [DATA_W-1:0] RST_FEN       = 16'hFFFF;
  localparam logic [DATA_W-1:0] RST_BPTR      = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 16'h0000;

  localparam logic [1:0] MSRC_M0   = 2'h0;
  localparam logic [1:0] MSRC_M1   = 2'h1;
  localparam logic [1:0] MSRC_M2   = 2'h2;
  localparam logic [1:0] MSRC_RSVD = 2'h3;
  localparam logic [PTR_W-1:0] BPTR_FIFO = 4'hF;
  localparam int MATCH_LATENCY = 1;

  function automatic logic [1:0] sel_field(input logic [31:0] sel_all, input logic [IDX_W-1:0] n);
    return sel_all[{n, 1'b0} +: 2];
  endfunction

  function automatic logic [PTR_W-1:0] get_ptr(input logic [63:0] all, input logic [IDX_W-1:0] n);
    return all[{n, 2'b00} +: 4];
  endfunction

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                    input logic [ADDR_W-1:0] cnt);
    return (a >= base) && (ADDR_W'(a - base) < cnt);
  endfunction

endpackage

//--- pkg/cafm_hit_if.sv
// Carrier between the filter array and the winner selector.
`timescale 1ns/100ps
interface cafm_hit_if;
  import cafm_pkg::*;
  logic [NUM_FILTERS-1:0] match_vec;
  logic                   hit;
  logic [IDX_W-1:0]       idx;
  modport src (output match_vec, input hit, input idx);
  modport sel (input match_vec, output hit, output idx);
endinterface

//--- hdl/cafm_filter_cmp.sv
// Identifier comparison of one filter against its selected mask.
`timescale 1ns/100ps
module cafm_filter_cmp (
  // Filter and mask contents
  input  wire logic [cafm_pkg::DATA_W-1:0] filt_sid,
  input  wire logic [cafm_pkg::DATA_W-1:0] filt_eid,
  input  wire logic [cafm_pkg::DATA_W-1:0] mask_sid,
  input  wire logic [cafm_pkg::DATA_W-1:0] mask_eid,
  // Received identifier
  input  wire logic [cafm_pkg::SID_W-1:0]  msg_sid,
  input  wire logic [cafm_pkg::EID_W-1:0]  msg_eid,
  input  wire logic                        msg_ext,
  // Result
  output logic                             match
);
  import cafm_pkg::*;

  function automatic logic masked_eq(input logic [EID_W-1:0] a, input logic [EID_W-1:0] b,
                                     input logic [EID_W-1:0] care);
    return ((a ^ b) & care) == 18'h0_0000;
  endfunction

  wire logic std_eq;
  wire logic ext_eq;
  wire logic mask_type_match_mode;
  wire logic filter_frame_type_select;
  wire logic type_ok;

  assign std_eq = masked_eq({7'h00, filt_sid[SID_MSB:SID_LSB]}, {7'h00, msg_sid},
                            {7'h00, mask_sid[SID_MSB:SID_LSB]});
  assign ext_eq = masked_eq({filt_sid[EIDH_MSB:0], filt_eid}, msg_eid,
                            {mask_sid[EIDH_MSB:0], mask_eid});
  assign mask_type_match_mode   = mask_sid[MASK_TYPE_MATCH_MODE_POS];
  assign filter_frame_type_select  = filt_sid[FILTER_FRAME_TYPE_SELECT_POS];
  assign type_ok = !mask_type_match_mode || (filter_frame_type_select == msg_ext);
  assign match  = type_ok && std_eq && (!msg_ext || ext_eq);

endmodule // cafm_filter_cmp

//--- hdl/cafm_prio_sel.sv
// Picks the lowest numbered matching filter.
`timescale 1ns/100ps
module cafm_prio_sel #(
  parameter int N = cafm_pkg::NUM_FILTERS
) (
  // Match vector in, winner out
  cafm_hit_if.sel hv
);
  import cafm_pkg::*;

  always_comb begin
    hv.hit = 1'b0;
    hv.idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hv.match_vec[i]) begin
        hv.hit = 1'b1;
        hv.idx = IDX_W'(i);
      end
    end
  end

endmodule // cafm_prio_sel

//--- hdl/cafm_top.sv
// Acceptance filter match block with its register file.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module cafm_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // Register port
  input  wire logic [cafm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cafm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [cafm_pkg::DATA_W-1:0] reg_rdata,
  // Identifier from the receive engine
  input  wire logic                        id_valid,
  input  wire logic [cafm_pkg::SID_W-1:0]  id_std,
  input  wire logic [cafm_pkg::EID_W-1:0]  id_ext,
  input  wire logic                        id_is_ext,
  // Match result
  output logic                             match_done,
  output logic                             match_hit,
  output logic      [cafm_pkg::IDX_W-1:0]  match_index,
  output logic      [cafm_pkg::PTR_W-1:0]  filter_hit_buffer_pointer
);
  import cafm_pkg::*;

  logic [DATA_W-1:0] filter_std_id_reg [NUM_FILTERS];
  logic [DATA_W-1:0] filter_ext_id_reg [NUM_FILTERS];
  logic [DATA_W-1:0] mask_std_id_reg   [NUM_MASKS];
  logic [DATA_W-1:0] mask_ext_id_reg   [NUM_MASKS];
  logic [DATA_W-1:0] buffer_ptr_reg    [4];
  logic [DATA_W-1:0] mask_select_low_reg;
  logic [DATA_W-1:0] mask_select_high_reg;
  logic [DATA_W-1:0] filter_accept_enable_reg;
  logic [DATA_W-1:0] reg_rdata_reg;
  logic              match_done_reg;
  logic              match_hit_reg;
  logic [IDX_W-1:0]  match_index_reg;
  logic [PTR_W-1:0]  match_ptr_reg;

  wire logic [31:0]          sel_all;
  wire logic [63:0]          bptr_all;
  wire logic [NUM_FILTERS-1:0] match_vec;
  wire logic [IDX_W-1:0]     wr_idx;
  wire logic                 in_fsid;
  wire logic                 in_feid;
  wire logic                 in_msid;
  wire logic                 in_meid;
  wire logic                 in_bptr;
  wire logic [DATA_W-1:0]    status_word;
  wire logic [DATA_W-1:0]    rd_mux;

  cafm_hit_if hv ();

  // Register address decode.
  assign in_fsid = in_range(reg_addr, ADDR_FSID_BASE, CNT_FILTERS);
  assign in_feid = in_range(reg_addr, ADDR_FEID_BASE, CNT_FILTERS);
  assign in_msid = in_range(reg_addr, ADDR_MSID_BASE, CNT_MASKS);
  assign in_meid = in_range(reg_addr, ADDR_MEID_BASE, CNT_MASKS);
  assign in_bptr = in_range(reg_addr, ADDR_BPTR_BASE, CNT_BPTR);
  assign wr_idx  = in_fsid ? IDX_W'(reg_addr - ADDR_FSID_BASE) :
                   in_feid ? IDX_W'(reg_addr - ADDR_FEID_BASE) :
                   in_msid ? IDX_W'(reg_addr - ADDR_MSID_BASE) :
                   in_meid ? IDX_W'(reg_addr - ADDR_MEID_BASE) :
                   IDX_W'(reg_addr - ADDR_BPTR_BASE);

  assign sel_all  = {mask_select_high_reg, mask_select_low_reg};
  assign bptr_all = {buffer_ptr_reg[3], buffer_ptr_reg[2], buffer_ptr_reg[1], buffer_ptr_reg[0]};

  assign status_word = {7'h00, match_hit_reg, match_index_reg, match_ptr_reg};

  // Read selection; unmapped addresses read zero.
  assign rd_mux = in_fsid ? filter_std_id_reg[wr_idx] & SID_IMPL_MASK :
                  in_feid ? filter_ext_id_reg[wr_idx] :
                  in_msid ? mask_std_id_reg[wr_idx[1:0]] & SID_IMPL_MASK :
                  in_meid ? mask_ext_id_reg[wr_idx[1:0]] :
                  in_bptr ? buffer_ptr_reg[wr_idx[1:0]] :
                  (reg_addr == ADDR_MSEL_LO) ? mask_select_low_reg :
                  (reg_addr == ADDR_MSEL_HI) ? mask_select_high_reg :
                  (reg_addr == ADDR_FEN) ? filter_accept_enable_reg :
                  (reg_addr == ADDR_STATUS) ? status_word :
                  DATA_ZERO;

  // Filter identifier storage.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filter_std_id_reg[i] <= RST_ID;
        filter_ext_id_reg[i] <= RST_ID;
      end
    end else if (reg_wr && in_fsid) begin
      filter_std_id_reg[wr_idx] <= reg_wdata & SID_IMPL_MASK;
    end else if (reg_wr && in_feid) begin
      filter_ext_id_reg[wr_idx] <= reg_wdata;
    end
  end

  // Mask storage.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_std_id_reg[i] <= RST_ID;
        mask_ext_id_reg[i] <= RST_ID;
      end
    end else if (reg_wr && in_msid) begin
      mask_std_id_reg[wr_idx[1:0]] <= reg_wdata & SID_IMPL_MASK;
    end else if (reg_wr && in_meid) begin
      mask_ext_id_reg[wr_idx[1:0]] <= reg_wdata;
    end
  end

  // Mask selection, enables and buffer pointers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_select_low_reg      <= RST_MSEL;
      mask_select_high_reg     <= RST_MSEL;
      filter_accept_enable_reg <= RST_FEN;
      for (int i = 0; i < 4; i++) begin
        buffer_ptr_reg[i] <= RST_BPTR;
      end
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MSEL_LO) begin
        mask_select_low_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_MSEL_HI) begin
        mask_select_high_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_FEN) begin
        filter_accept_enable_reg <= reg_wdata;
      end
      if (in_bptr) begin
        buffer_ptr_reg[wr_idx[1:0]] <= reg_wdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_reg <= DATA_ZERO;
    end else begin
      reg_rdata_reg <= reg_rd ? rd_mux : DATA_ZERO;
    end
  end

  // One comparator per filter, fed by the mask its select field names.
  for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_filt
    wire logic [1:0] src;
    wire logic       src_ok;
    wire logic [1:0] mi;
    wire logic       raw;
    assign src    = sel_field(sel_all, IDX_W'(g));
    assign src_ok = (src != MSRC_RSVD);
    assign mi     = src_ok ? src : MSRC_M0;
    cafm_filter_cmp u_cmp (
      .filt_sid (filter_std_id_reg[g]),
      .filt_eid (filter_ext_id_reg[g]),
      .mask_sid (mask_std_id_reg[mi]),
      .mask_eid (mask_ext_id_reg[mi]),
      .msg_sid  (id_std),
      .msg_eid  (id_ext),
      .msg_ext  (id_is_ext),
      .match    (raw)
    );
    assign match_vec[g] = raw && src_ok && filter_accept_enable_reg[g];

    // Per-filter checks on select, enable and frame type gating.
    wire logic       type_gate;
    assign type_gate = id_valid && mask_std_id_reg[mi][MASK_TYPE_MATCH_MODE_POS] && (filter_std_id_reg[g][FILTER_FRAME_TYPE_SELECT_POS] != id_is_ext);

    AST_RSVD_NEVER: assert property (@(posedge core_clk) disable iff (!rst_n) !src_ok |-> !match_vec[g])
      else $error("Filter with reserved mask select took part.");
    AST_EN_NEEDED: assert property (@(posedge core_clk) disable iff (!rst_n) !filter_accept_enable_reg[g] |-> !match_vec[g])
      else $error("Disabled filter took part in acceptance.");
    AST_TYPE_GATE: assert property (@(posedge core_clk) disable iff (!rst_n) type_gate |-> !match_vec[g])
      else $error("Filter accepted a frame of the excluded type.");
  end

  assign hv.match_vec = match_vec;

  cafm_prio_sel #(
    .N (NUM_FILTERS)
  ) u_prio (
    .hv (hv)
  );

  // Result registers, loaded once per presented identifier.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      match_done_reg  <= 1'b0;
      match_hit_reg   <= 1'b0;
      match_index_reg <= 4'h0;
      match_ptr_reg   <= 4'h0;
    end else begin
      match_done_reg <= id_valid;
      if (id_valid) begin
        match_hit_reg   <= hv.hit;
        match_index_reg <= hv.hit ? hv.idx : 4'h0;
        match_ptr_reg   <= hv.hit ? get_ptr(bptr_all, hv.idx) : 4'h0;
      end
    end
  end

  assign reg_rdata                 = reg_rdata_reg;
  assign match_done                = match_done_reg;
  assign match_hit                 = match_hit_reg;
  assign match_index               = match_index_reg;
  assign filter_hit_buffer_pointer = match_ptr_reg;

  // Checks on filter zero and on the result path.
  wire logic [1:0]        f0_src;
  wire logic [1:0]        f0_mi;
  wire logic              f0_mask_type_match_mode;
  wire logic [SID_W-1:0]  f0_sid_diff;
  wire logic [EID_W-1:0]  f0_eid_diff;
  wire logic [NUM_FILTERS-1:0] below_win;

  assign f0_src      = sel_field(sel_all, 4'h0);
  assign f0_mi       = (f0_src == MSRC_RSVD) ? MSRC_M0 : f0_src;
  assign f0_mask_type_match_mode     = mask_std_id_reg[f0_mi][MASK_TYPE_MATCH_MODE_POS];
  assign f0_sid_diff = (filter_std_id_reg[0][SID_MSB:SID_LSB] ^ id_std) &
                       mask_std_id_reg[f0_mi][SID_MSB:SID_LSB];
  assign f0_eid_diff = ({filter_std_id_reg[0][EIDH_MSB:0], filter_ext_id_reg[0]} ^ id_ext) &
                       {mask_std_id_reg[f0_mi][EIDH_MSB:0], mask_ext_id_reg[f0_mi]};
  assign below_win   = match_vec & ((16'h0001 << hv.idx) - 16'h0001);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    id_valid;
  endsequence

  sequence s_answer;
    ##1 match_done_reg;
  endsequence

  sequence s_hit_take;
    id_valid && hv.hit;
  endsequence

  AST_DONE_LATENCY: assert property (s_take |-> s_answer)
    else $error("Result did not follow the identifier by one cycle.");
  AST_DONE_CAUSE: assert property (match_done_reg |-> $past(id_valid))
    else $error("Result strobe without a presented identifier.");
  AST_MISS_CLEAN: assert property (id_valid && !hv.hit |=> !match_hit_reg && match_index_reg == 4'h0)
    else $error("Miss reported with hit flag or index.");
  AST_ENABLED_WIN: assert property (s_hit_take |-> filter_accept_enable_reg[hv.idx]
                                    ##1 match_index_reg == $past(hv.idx))
    else $error("Winner is disabled or index not reported.");
  AST_DISABLED_F0: assert property (id_valid && !filter_accept_enable_reg[0] |-> !match_vec[0])
    else $error("Disabled filter zero matched.");
  AST_LOWEST_WINS: assert property (s_hit_take |-> below_win == 16'h0000 && match_vec[hv.idx])
    else $error("A lower numbered filter also matched.");
  AST_RESERVED_SEL: assert property (s_hit_take |-> sel_field(sel_all, hv.idx) != MSRC_RSVD)
    else $error("Filter with reserved mask select matched.");
  AST_BUFPTR: assert property (s_hit_take |=> filter_hit_buffer_pointer == $past(get_ptr(bptr_all, hv.idx)))
    else $error("Buffer pointer does not belong to the winner.");
  AST_READ_ZERO: assert property (reg_rd && (in_fsid || in_msid) |=> (reg_rdata_reg & ~SID_IMPL_MASK) == 16'h0000)
    else $error("Unimplemented identifier bits read nonzero.");
  AST_TYPE_STD: assert property (id_valid && f0_mask_type_match_mode && filter_std_id_reg[0][FILTER_FRAME_TYPE_SELECT_POS] && !id_is_ext
                                 |-> !match_vec[0])
    else $error("Extended-only filter accepted a standard frame.");
  AST_TYPE_EXT: assert property (id_valid && f0_mask_type_match_mode && !filter_std_id_reg[0][FILTER_FRAME_TYPE_SELECT_POS] && id_is_ext
                                 |-> !match_vec[0])
    else $error("Standard-only filter accepted an extended frame.");
  AST_EITHER_TYPE: assert property (id_valid && !f0_mask_type_match_mode && f0_src != MSRC_RSVD && filter_accept_enable_reg[0]
                                    && f0_sid_diff == 11'h000 && !id_is_ext |-> match_vec[0] && hv.hit)
    else $error("Standard frame refused although type is ignored.");
  AST_SID_CARE: assert property (id_valid && f0_sid_diff != 11'h000 |-> !match_vec[0])
    else $error("Filter zero matched despite a cared standard bit.");
  AST_EID_CARE: assert property (id_valid && id_is_ext && f0_eid_diff != 18'h0_0000 |-> !match_vec[0])
    else $error("Filter zero matched despite a cared extended bit.");

  // Result holds between identifiers; read data stands one cycle only.
  sequence s_idle;
    !id_valid;
  endsequence

  AST_RESULT_HOLD: assert property (s_idle |=> $stable(match_hit_reg) && $stable(match_index_reg) && $stable(match_ptr_reg))
    else $error("Match result changed without a presented identifier.");
  AST_NO_DONE_IDLE: assert property (s_idle |=> !match_done_reg)
    else $error("Result strobe rose without a presented identifier.");
  AST_MISS_PTR: assert property (id_valid && !hv.hit |=> filter_hit_buffer_pointer == 4'h0)
    else $error("Miss reported with a buffer pointer.");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_reg == DATA_ZERO)
    else $error("Read data stood without a read strobe.");
  AST_STATUS_HIT: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata_reg[STAT_HIT_POS] == $past(match_hit_reg))
    else $error("Status read does not mirror the hit flag.");

endmodule // cafm_top

//--- verif/cafm_rx_model.sv
// Behavioural receive engine that presents decoded identifiers to the block.
`timescale 1ns/100ps
module cafm_rx_model (
  // Clock
  input  wire logic                       core_clk,
  // Identifier to the block
  output logic                            id_valid,
  output logic      [cafm_pkg::SID_W-1:0] id_std,
  output logic      [cafm_pkg::EID_W-1:0] id_ext,
  output logic                            id_is_ext
);
  import cafm_pkg::*;

  initial begin
    id_valid  = 1'b0;
    id_std    = 11'h000;
    id_ext    = 18'h0_0000;
    id_is_ext = 1'b0;
  end

  // Presents one identifier for one cycle, then scrambles the idle lines.
  task automatic send(input logic [SID_W-1:0] s, input logic [EID_W-1:0] e, input logic x);
    @(posedge core_clk);
    id_valid  <= 1'b1;
    id_std    <= s;
    id_ext    <= e;
    id_is_ext <= x;
    @(posedge core_clk);
    id_valid  <= 1'b0;
    id_std    <= ~s;
    id_ext    <= ~e;
    id_is_ext <= ~x;
  endtask
endmodule // cafm_rx_model

//--- verif/tb_can_acceptance_filter_match.sv
// Self-checking testbench for the acceptance filter match block.
`timescale 1ns/100ps
module tb_can_acceptance_filter_match;
  import cafm_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              id_valid;
  logic [SID_W-1:0]  id_std;
  logic [EID_W-1:0]  id_ext;
  logic              id_is_ext;
  logic              match_done;
  logic              match_hit;
  logic [IDX_W-1:0]  match_index;
  logic [PTR_W-1:0]  filter_hit_buffer_pointer;
  int                n_mismatch   = 0;
  int                total_checks = 0;
  int                cycles       = 0;

  cafm_top dut (
    .core_clk                  (core_clk),
    .rst_n                     (rst_n),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .id_valid                  (id_valid),
    .id_std                    (id_std),
    .id_ext                    (id_ext),
    .id_is_ext                 (id_is_ext),
    .match_done                (match_done),
    .match_hit                 (match_hit),
    .match_index               (match_index),
    .filter_hit_buffer_pointer (filter_hit_buffer_pointer)
  );

  cafm_rx_model rx (
    .core_clk  (core_clk),
    .id_valid  (id_valid),
    .id_std    (id_std),
    .id_ext    (id_ext),
    .id_is_ext (id_is_ext)
  );

  always #25 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // The run needs well under a thousand cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Sends one identifier and checks the result strobe, then that the result holds.
  task automatic ident(input logic [10:0] s, input logic [17:0] e, input logic x,
                       input logic h, input logic [3:0] idx, input logic [3:0] ptr);
    rx.send(s, e, x);
    #1;
    chk({6'h00, match_done, match_hit, match_index, filter_hit_buffer_pointer}, {6'h00, 1'b1, h, idx, ptr});
    @(posedge core_clk);
    #1;
    chk({6'h00, match_done, match_hit, match_index, filter_hit_buffer_pointer}, {6'h00, 1'b0, h, idx, ptr});
  endtask

  task automatic done(input string name);
    $display("test %s ended, checks %0d mismatches %0d", name, total_checks, n_mismatch);
  endtask

  initial begin
    logic h;
    core_clk  = 1'b0;
    rst_n     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({6'h00, match_done, match_hit, match_index, filter_hit_buffer_pointer}, 16'h0000);
    rdchk(ADDR_MSEL_LO, 16'h0000);
    rdchk(ADDR_MSEL_HI, 16'h0000);
    rdchk(ADDR_FEN, 16'hFFFF);
    rdchk(ADDR_BPTR_BASE, 16'h0000);
    rdchk(8'h30, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      wr(8'(n), 16'hFFFF);
      wr(ADDR_FEID_BASE + 8'(n), 16'(n));
    end
    for (int n = 0; n < 16; n++) begin
      rdchk(8'(n), 16'hFFEB);
      rdchk(ADDR_FEID_BASE + 8'(n), 16'(n));
    end
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_MSID_BASE + 8'(m), 16'hFFFF);
      rdchk(ADDR_MSID_BASE + 8'(m), 16'hFFEB);
      wr(ADDR_MSID_BASE + 8'(m), 16'h0000);
    end
    done("registers");
    ident(11'h000, 18'h0_0000, 1'b0, 1'b1, 4'h0, 4'h0);
    wr(ADDR_FEN, 16'h0020);
    wr(ADDR_MSEL_LO, 16'h0400);
    wr(ADDR_MSID_BASE + 8'h01, 16'hFFE3);
    wr(ADDR_MEID_BASE + 8'h01, 16'hFFFF);
    wr(8'h05, 16'h2462);
    wr(8'h15, 16'hBEEF);
    wr(ADDR_BPTR_BASE + 8'h01, 16'h00F0);
    ident(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'h5, 4'hF);
    ident(11'h122, 18'h0_0000, 1'b0, 1'b0, 4'h0, 4'h0);
    ident(11'h123, 18'h2_BEEF, 1'b1, 1'b1, 4'h5, 4'hF);
    ident(11'h123, 18'h2_BEEE, 1'b1, 1'b0, 4'h0, 4'h0);
    ident(11'h123, 18'h0_BEEF, 1'b1, 1'b0, 4'h0, 4'h0);
    wr(ADDR_MEID_BASE + 8'h01, 16'hFFFE);
    wr(ADDR_MSID_BASE + 8'h01, 16'hFFC1);
    ident(11'h122, 18'h0_BEEE, 1'b1, 1'b1, 4'h5, 4'hF);
    done("masking");
    wr(ADDR_MSID_BASE + 8'h01, 16'hFFEB);
    ident(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'h5, 4'hF);
    ident(11'h123, 18'h2_BEEF, 1'b1, 1'b0, 4'h0, 4'h0);
    wr(8'h05, 16'h246A);
    ident(11'h123, 18'h2_BEEF, 1'b1, 1'b1, 4'h5, 4'hF);
    ident(11'h123, 18'h2_BEEF, 1'b0, 1'b0, 4'h0, 4'h0);
    wr(ADDR_MSID_BASE + 8'h01, 16'hFFE3);
    ident(11'h123, 18'h0_0000, 1'b0, 1'b1, 4'h5, 4'hF);
    done("frame type");
    for (int c = 0; c < 4; c++) begin
      h = (c == 0) || (c == 2);
      wr(ADDR_MSEL_LO, 16'(c) << 10);
      ident(11'h122, 18'h0_0000, 1'b0, h, h ? 4'h5 : 4'h0, h ? 4'hF : 4'h0);
    end
    done("mask select");
    wr(ADDR_FEN, 16'h1200);
    wr(ADDR_MSEL_HI, 16'h0000);
    wr(ADDR_BPTR_BASE + 8'h02, 16'h00A0);
    wr(ADDR_BPTR_BASE + 8'h03, 16'h0003);
    ident(11'h000, 18'h0_0000, 1'b0, 1'b1, 4'h9, 4'hA);
    wr(ADDR_MSEL_HI, 16'h000C);
    ident(11'h000, 18'h0_0000, 1'b0, 1'b1, 4'hC, 4'h3);
    rdchk(ADDR_STATUS, 16'h01C3);
    wr(ADDR_FEN, 16'h0200);
    ident(11'h000, 18'h0_0000, 1'b0, 1'b0, 4'h0, 4'h0);
    done("priority");
    summarize();
  end
endmodule // tb_can_acceptance_filter_match
